// ### hw/poll_addr_pkg.sv
package poll_addr_pkg;

  // Register offsets, relative to the board base address
  localparam int         REG_ADDR_W        = 9;
  localparam logic [8:0] OFS_POLL          = 9'h117;
  localparam logic [8:0] OFS_ADDR_STATUS   = 9'h119;

  // Field positions in the poll registers
  localparam int         POLL_BIT_RSV      = 6;
  localparam logic [7:0] POLL_STATUS_MASK  = 8'hbf;
  localparam logic [7:0] POLL_STATUS_RESET = 8'h00;

  // Multiline command bytes and groups
  localparam logic [6:0] CMD_SPE           = 7'h18;
  localparam logic [6:0] CMD_SPD           = 7'h19;
  localparam logic [6:0] CMD_UNL           = 7'h3f;
  localparam logic [6:0] CMD_UNT           = 7'h5f;
  localparam logic [1:0] GRP_LISTEN        = 2'h1;
  localparam logic [1:0] GRP_TALK          = 2'h2;
  localparam logic [1:0] GRP_SECONDARY     = 2'h3;
  localparam logic [4:0] ADDR_ALL_ONES     = 5'h1f;

  // Addressing modes
  localparam logic [1:0] MODE_TON_LON      = 2'h0;
  localparam logic [1:0] MODE_DUAL         = 2'h1;
  localparam logic [1:0] MODE_EXT_SINGLE   = 2'h2;
  localparam logic [1:0] MODE_EXT_DUAL     = 2'h3;

  // Talker and listener function states
  typedef enum logic [1:0] {T_IDLE, T_ADDRESSED, T_ACTIVE, T_POLL} talker_e;
  typedef enum logic [1:0] {L_IDLE, L_ADDRESSED, L_ACTIVE} listener_e;

endpackage : poll_addr_pkg

// ### hw/sticky_flag.sv
`timescale 1ns/1ps
// Sticky flag: a set in the same cycle as a clear wins
module sticky_flag
(
  input  wire logic clk,    // Clock
  input  wire logic rst_n,  // Synchronised reset, active low
  input  wire logic set,    // Set request
  input  wire logic clr,    // Clear request
  output logic      q       // Flag value
);

  typedef struct packed
  {
    logic flag;
  } flag_s;

  flag_s state_reg;
  flag_s state_next;

  // Next value, set has priority
  always_comb
  begin
    state_next = state_reg;
    if (set)
      state_next.flag = 1'b1;
    else if (clr)
      state_next.flag = 1'b0;
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign q = state_reg.flag;

endmodule : sticky_flag

// ### hw/serial_poll_address_status.sv
`timescale 1ns/1ps
// Operation
// - Send stored status byte during serial poll
// - Reset and chip reset clear status bits
// - Request-service outside poll asserts SRQ
// - Affirmative poll response and resets clear request
// - Pending follows request, clears after negative response
// - Poll status and mode share one address
// - Address status bit order fixed
// - Controller bit is inverse of idle and addressed states
// - Attention bit mirrors bus ATN level
// - Poll mode set by enable while talker active, cleared by disable, local master clear, chip reset
// - Extended listen primary address sets flag
// - Extended talk primary address sets flag
// - Listener active in addressed or active states
// - Talker active in addressed, active, poll states
// - Listen address unaddresses talker, and vice versa
// - Major/minor follows received address kind
// - Major/minor zero outside dual primary modes
// - Address change flag on talker, listener, controller or major/minor bit change, except talk/listen only
// - Listen-only and talk-only need no addressing in mode 0
module serial_poll_address_status
  import poll_addr_pkg::*;
(
  input  wire logic                           CLK,                 // 20 MHz clock
  input  wire logic                           RST_B,               // Power-on reset, active low
  input  wire logic [poll_addr_pkg::REG_ADDR_W-1:0] REG_ADDR,      // Register offset
  input  wire logic [7:0]                     REG_WDATA,           // Write data
  input  wire logic                           REG_WR,              // Write strobe, one cycle
  input  wire logic                           REG_RD,              // Read strobe, one cycle
  output logic      [7:0]                     REG_RDATA,           // Read data, one cycle after strobe
  input  wire logic                           ATN_B,               // Bus ATN line, low when asserted
  input  wire logic                           CMD_VALID,           // Command byte accepted from bus
  input  wire logic [7:0]                     CMD_BYTE,            // Command byte
  input  wire logic                           CIDS,                // Controller idle state
  input  wire logic                           CADS,                // Controller addressed state
  input  wire logic [1:0]                     ADDR_MODE,           // Addressing mode
  input  wire logic                           TALK_ONLY,           // Talk-only programming
  input  wire logic                           LISTEN_ONLY,         // Listen-only programming
  input  wire logic [4:0]                     MAJOR_ADDR,          // Major / primary address
  input  wire logic [4:0]                     MINOR_ADDR,          // Minor / secondary address
  input  wire logic                           CHIP_RESET,          // Chip reset command, pulse
  input  wire logic                           LOCAL_MASTER_CLEAR,  // Local master clear, pulse
  input  wire logic                           ISR_READ,            // Interrupt status read, pulse
  input  wire logic                           POLL_TAKEN,          // Controller took status byte
  output logic      [7:0]                     POLL_BYTE,           // Status byte to the bus
  output logic                                POLL_BYTE_VALID,     // Status byte being offered
  output logic                                SRQ_O,               // SRQ pin output level
  output logic                                SRQ_OE_B,            // SRQ pin enable, low drives
  output logic                                ADDR_CHANGE          // Addressed change flag
);

  typedef struct packed
  {
    logic [7:0] status;
    logic       rsv;
    talker_e    talk;
    listener_e  listen;
    logic       poll_mode_state_flag;
    logic       listen_primary_flag;
    logic       talk_primary_flag;
    logic       major_minor_select;
    logic [3:0] prev_bits;
    logic       primed;
    logic [7:0] rdata;
    logic [7:0] poll_out;
  } state_s;

  state_s     state_reg;
  state_s     state_next;
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic       pending;
  logic       addressed_change_flag;
  logic       atn;
  logic       cmd_take;
  logic [1:0] cmd_grp;
  logic [4:0] cmd_addr;
  logic       dual_mode;
  logic       ext_mode;
  logic       hit_major;
  logic       hit_minor;
  logic       my_listen;
  logic       my_talk;
  logic       other_talk;
  logic       talker_on;
  logic       listener_on;
  logic       controller_in_charge_flag;
  logic [3:0] cur_bits;
  logic       nprs_clear;
  logic       addressed_change_flag_set;
  logic [7:0] poll_read;
  logic [7:0] addr_read;

  // Reset release through two flip-flops
  // Only the second flip-flop feeds the design, so release is never metastable
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  // Command decode
  // Bit 7 of a command byte carries no meaning here and is ignored
  assign atn         = ~ATN_B;
  assign cmd_take    = CMD_VALID & atn;
  assign cmd_grp     = CMD_BYTE[6:5];
  assign cmd_addr    = CMD_BYTE[4:0];
  assign dual_mode   = (ADDR_MODE == MODE_DUAL) | (ADDR_MODE == MODE_EXT_DUAL);
  assign ext_mode    = (ADDR_MODE == MODE_EXT_SINGLE) | (ADDR_MODE == MODE_EXT_DUAL);
  assign hit_major   = (cmd_addr == MAJOR_ADDR);
  assign hit_minor   = dual_mode & (cmd_addr == MINOR_ADDR);
  assign my_listen   = (cmd_grp == GRP_LISTEN) & (cmd_addr != ADDR_ALL_ONES) & (hit_major | hit_minor);
  assign my_talk     = (cmd_grp == GRP_TALK) & (cmd_addr != ADDR_ALL_ONES) & (hit_major | hit_minor);
  assign other_talk  = (cmd_grp == GRP_TALK) & (cmd_addr != ADDR_ALL_ONES) & ~(hit_major | hit_minor);

  // Address status bits derived from function states
  // The controller bit follows its inputs directly, with no flop
  assign talker_on   = (state_reg.talk != T_IDLE);
  assign listener_on = (state_reg.listen != L_IDLE);
  assign controller_in_charge_flag         = ~(CIDS | CADS);
  assign cur_bits    = {talker_on, listener_on, controller_in_charge_flag, state_reg.major_minor_select};

  // Negative poll response with no request clears pending; a request that
  // still stands keeps it set, as the set input wins
  assign nprs_clear  = (state_reg.talk != T_POLL) & ~state_reg.rsv;

  // Any change of the watched bits, unless programmed talk or listen only;
  // the first cycle out of reset only loads the history, so no false change
  assign addressed_change_flag_set    = state_reg.primed & (cur_bits != state_reg.prev_bits) &
                       ~(LISTEN_ONLY | TALK_ONLY);

  // Read views of the two registers
  assign poll_read   = (state_reg.status & POLL_STATUS_MASK) |
                       ({7'h00, pending} << POLL_BIT_RSV);
  assign addr_read   = {controller_in_charge_flag, ATN_B, state_reg.poll_mode_state_flag, state_reg.listen_primary_flag,
                        state_reg.talk_primary_flag, listener_on, talker_on, state_reg.major_minor_select};

  // Pending flag, set while a request stands; it drops whenever the talker is
  // outside the poll state with the request already withdrawn
  sticky_flag u_pending
  (
    .clk   (CLK),
    .rst_n (rst_n),
    .set   (state_reg.rsv),
    .clr   (nprs_clear),
    .q     (pending)
  );

  // Addressed change flag, cleared by reading interrupt status
  sticky_flag u_addressed_change_flag
  (
    .clk   (CLK),
    .rst_n (rst_n),
    .set   (addressed_change_flag_set),
    .clr   (ISR_READ),
    .q     (addressed_change_flag)
  );

  // Next state of the whole block
  always_comb
  begin
    state_next           = state_reg;

    // History of the watched bits; primed keeps the first cycle out of reset
    // from looking like a change
    state_next.prev_bits = cur_bits;
    state_next.primed    = 1'b1;

    // Host writes to the shared poll address; bit 6 is the request, and the
    // pending flag is only ever seen on reads
    if (REG_WR && (REG_ADDR == OFS_POLL))
    begin
      state_next.status = REG_WDATA & POLL_STATUS_MASK;
      state_next.rsv    = REG_WDATA[POLL_BIT_RSV];
    end
    else if (POLL_TAKEN && (state_reg.talk == T_POLL) && state_reg.rsv)
    begin
      // Affirmative poll response drops the request
      state_next.rsv = 1'b0;
    end

    // Register read, answered on the next cycle
    // Unmapped offsets read as zero
    if (REG_RD)
    begin
      case (REG_ADDR)
        OFS_POLL:        state_next.rdata = poll_read;
        OFS_ADDR_STATUS: state_next.rdata = addr_read;
        default:         state_next.rdata = 8'h00;
      endcase
    end

    // Programmed talker or listener without bus addressing
    // These programming bits only address in mode 0, where commands are ignored
    if (ADDR_MODE == MODE_TON_LON)
    begin
      if (TALK_ONLY && (state_reg.talk == T_IDLE))
        state_next.talk = T_ADDRESSED;
      if (LISTEN_ONLY && (state_reg.listen == L_IDLE))
        state_next.listen = L_ADDRESSED;
    end
    else if (cmd_take)
    begin
      // Serial poll enable and disable
      if ((CMD_BYTE[6:0] == CMD_SPE) && talker_on)
        state_next.poll_mode_state_flag = 1'b1;
      if (CMD_BYTE[6:0] == CMD_SPD)
        state_next.poll_mode_state_flag = 1'b0;
      if (CMD_BYTE[6:0] == CMD_UNL)
        state_next.listen = L_IDLE;
      if (CMD_BYTE[6:0] == CMD_UNT)
        state_next.talk = T_IDLE;

      if (!ext_mode)
      begin
        // Normal addressing: primary address addresses at once
        if (my_listen)
        begin
          state_next.listen = L_ADDRESSED;
          state_next.talk   = T_IDLE;
          state_next.major_minor_select   = ~hit_major;
        end
        else if (my_talk)
        begin
          state_next.talk   = T_ADDRESSED;
          state_next.listen = L_IDLE;
          state_next.major_minor_select   = ~hit_major;
        end
        else if (other_talk)
          state_next.talk = T_IDLE;
      end
      else if (cmd_grp != GRP_SECONDARY)
      begin
        // Extended addressing: primary address arms a secondary
        state_next.listen_primary_flag = my_listen;
        state_next.talk_primary_flag = my_talk;
        if (my_listen || my_talk)
          state_next.major_minor_select = ~hit_major;
        if (other_talk)
          state_next.talk = T_IDLE;
      end
      else if (cmd_addr != ADDR_ALL_ONES)
      begin
        // Secondary byte: single mode checks it, dual mode takes it
        if (state_reg.listen_primary_flag && ((ADDR_MODE == MODE_EXT_DUAL) || (cmd_addr == MINOR_ADDR)))
        begin
          state_next.listen = L_ADDRESSED;
          state_next.talk   = T_IDLE;
        end
        else if (state_reg.talk_primary_flag && ((ADDR_MODE == MODE_EXT_DUAL) || (cmd_addr == MINOR_ADDR)))
        begin
          state_next.talk   = T_ADDRESSED;
          state_next.listen = L_IDLE;
        end
        state_next.listen_primary_flag = 1'b0;
        state_next.talk_primary_flag = 1'b0;
      end
    end

    // Addressed functions go active when ATN is released
    // ATN held low keeps them addressed, so only a command in the first ATN cycle can meet an active talker
    case (state_next.talk)
      T_IDLE:      state_next.talk = T_IDLE;
      T_ADDRESSED,
      T_ACTIVE,
      T_POLL:
      begin
        if (atn)
          state_next.talk = T_ADDRESSED;
        else if (state_next.poll_mode_state_flag)
          state_next.talk = T_POLL;
        else
          state_next.talk = T_ACTIVE;
      end
      default:     state_next.talk = T_IDLE;
    endcase

    case (state_next.listen)
      L_IDLE:      state_next.listen = L_IDLE;
      L_ADDRESSED,
      L_ACTIVE:    state_next.listen = atn ? L_ADDRESSED : L_ACTIVE;
      default:     state_next.listen = L_IDLE;
    endcase

    // Major/minor only has meaning in dual primary modes
    if (!dual_mode)
      state_next.major_minor_select = 1'b0;

    // Status byte offered to the controller: stored bits plus request
    state_next.poll_out = (state_next.status & POLL_STATUS_MASK) |
                          ({7'h00, state_next.rsv} << POLL_BIT_RSV);

    // Local master clear drops poll mode and primary flags
    // It leaves the addressed talker and listener functions as they are
    if (LOCAL_MASTER_CLEAR)
    begin
      state_next.poll_mode_state_flag = 1'b0;
      state_next.listen_primary_flag = 1'b0;
      state_next.talk_primary_flag = 1'b0;
    end

    // Chip reset command returns the functions to idle
    // Pending follows one cycle later through its own flag
    if (CHIP_RESET)
    begin
      state_next.status   = POLL_STATUS_RESET;
      state_next.rsv      = 1'b0;
      state_next.talk     = T_IDLE;
      state_next.listen   = L_IDLE;
      state_next.poll_mode_state_flag     = 1'b0;
      state_next.listen_primary_flag     = 1'b0;
      state_next.talk_primary_flag     = 1'b0;
      state_next.major_minor_select     = 1'b0;
      state_next.poll_out = POLL_STATUS_RESET;
    end
  end

  // State register; power-on reset clears everything
  // Chip reset is a command, not a reset, so it goes through the next-state logic
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  // Outputs
  assign REG_RDATA       = state_reg.rdata;
  assign POLL_BYTE       = state_reg.poll_out;
  assign POLL_BYTE_VALID = (state_reg.talk == T_POLL);
  assign ADDR_CHANGE     = addressed_change_flag;

  // SRQ is open drain: the level stays low and only the enable moves;
  // the request is withheld while the controller is polling this talker
  assign SRQ_O           = 1'b0;
  assign SRQ_OE_B        = ~(state_reg.rsv & (state_reg.talk != T_POLL));

endmodule : serial_poll_address_status

// ### tb/poll_addr_properties.sv
`timescale 1ns/1ps
// Port-level checks of the poll and address status block
module poll_addr_props
  import poll_addr_pkg::*;
(
  input wire logic                                  CLK,             // Clock
  input wire logic                                  RST_B,           // Reset, active low
  input wire logic [poll_addr_pkg::REG_ADDR_W-1:0]  REG_ADDR,        // Register offset
  input wire logic [7:0]                            REG_WDATA,       // Write data
  input wire logic                                  REG_WR,          // Write strobe
  input wire logic                                  REG_RD,          // Read strobe
  input wire logic [7:0]                            REG_RDATA,       // Read data
  input wire logic                                  ATN_B,           // Attention level
  input wire logic                                  CIDS,            // Controller idle
  input wire logic                                  CADS,            // Controller addressed
  input wire logic                                  CHIP_RESET,      // Chip reset pulse
  input wire logic                                  ISR_READ,        // Status read pulse
  input wire logic                                  POLL_TAKEN,      // Byte accepted
  input wire logic [7:0]                            POLL_BYTE,       // Status byte
  input wire logic                                  POLL_BYTE_VALID, // Byte offered
  input wire logic                                  SRQ_OE_B,        // Request drive, low drives
  input wire logic                                  ADDR_CHANGE      // Addressed change flag
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  // Status byte and request flag follow host writes and their clearing events
  AST_POLL_WRITE: assert property (
    REG_WR && REG_ADDR == OFS_POLL && !CHIP_RESET |=> POLL_BYTE == $past(REG_WDATA))
    else $error("poll byte differs from host write");
  AST_CHIP_CLEAR: assert property (CHIP_RESET && !REG_WR |=> POLL_BYTE == 8'h00)
    else $error("chip reset left poll byte set");
  AST_TAKEN_CLEARS: assert property (POLL_TAKEN && POLL_BYTE_VALID && !REG_WR |=> !POLL_BYTE[6])
    else $error("request flag kept after byte taken");
  AST_SRQ_DRIVE: assert property (SRQ_OE_B == !(POLL_BYTE[6] && !POLL_BYTE_VALID))
    else $error("request line drive disagrees with flag and poll state");
  // Address status readback against the bus levels at the strobe
  AST_ATN_READ: assert property (REG_RD && REG_ADDR == OFS_ADDR_STATUS |=> REG_RDATA[6] == $past(ATN_B))
    else $error("attention bit wrong");
  AST_CIC_READ: assert property (
    REG_RD && REG_ADDR == OFS_ADDR_STATUS |=> REG_RDATA[7] == !($past(CIDS) || $past(CADS)))
    else $error("controller bit wrong");
  AST_ONE_ROLE: assert property (
    REG_RD && REG_ADDR == OFS_ADDR_STATUS |=> !(REG_RDATA[2] && REG_RDATA[1]))
    else $error("talker and listener both set");
  AST_UNMAPPED: assert property (
    REG_RD && REG_ADDR != OFS_POLL && REG_ADDR != OFS_ADDR_STATUS |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  AST_CHANGE_STICKY: assert property (ADDR_CHANGE && !ISR_READ |=> ADDR_CHANGE)
    else $error("change flag dropped without status read");
endmodule : poll_addr_props

bind serial_poll_address_status poll_addr_props chk (.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ATN_B(ATN_B),
  .CIDS(CIDS), .CADS(CADS), .CHIP_RESET(CHIP_RESET), .ISR_READ(ISR_READ), .POLL_TAKEN(POLL_TAKEN),
  .POLL_BYTE(POLL_BYTE), .POLL_BYTE_VALID(POLL_BYTE_VALID), .SRQ_OE_B(SRQ_OE_B), .ADDR_CHANGE(ADDR_CHANGE));

// ### tb/bus_ctrl_model.sv
`timescale 1ns/1ps
// Controller in charge: drives attention, command bytes and byte acceptance
module bus_ctrl_model
(
  input  wire logic       clk,        // Clock
  output logic            atn_b,      // Attention, low asserted
  output logic            cmd_valid,  // Command strobe
  output logic      [7:0] cmd_byte,   // Command byte
  output logic            poll_taken, // Status byte accepted
  output logic            cids,       // Controller idle
  output logic            cads        // Controller addressed
);
  // Idle bus at time zero
  initial
  begin
    atn_b = 1'b1;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    poll_taken = 1'b0;
    cids = 1'b0;
    cads = 1'b0;
  end
  // One command under attention; released lines show the inverse so stale data never matches
  task automatic send_cmd(input logic [7:0] b);
    @(negedge clk);
    atn_b = 1'b0;
    cmd_valid = 1'b1;
    cmd_byte = b;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_byte = ~b;
  endtask : send_cmd
  task automatic set_atn(input logic v);
    @(negedge clk);
    atn_b = v;
  endtask : set_atn
  task automatic set_idle(input logic idle_v, input logic addr_v);
    @(negedge clk);
    cids = idle_v;
    cads = addr_v;
  endtask : set_idle
  task automatic take_byte();
    @(negedge clk);
    poll_taken = 1'b1;
    @(negedge clk);
    poll_taken = 1'b0;
  endtask : take_byte
endmodule : bus_ctrl_model

// ### tb/serial_poll_address_status_tb_top.sv
`timescale 1ns/1ps
// Directed bench for the poll and address status block
module serial_poll_address_status_tb_top;
  import poll_addr_pkg::*;
  localparam logic [4:0] MAJ = 5'h05;
  localparam logic [4:0] MIN = 5'h0a;
  logic       clk, rst_b, reg_wr, reg_rd, atn_b, cmd_valid, cids, cads, talk_only, listen_only;
  logic       chip_reset, lmc, isr_read, poll_taken, poll_valid, srq_o, srq_oe_b, addr_change;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, cmd_byte, poll_byte;
  logic [1:0] addr_mode;
  int         fails, tests_run;

  serial_poll_address_status DUT (.CLK(clk), .RST_B(rst_b), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ATN_B(atn_b), .CMD_VALID(cmd_valid),
    .CMD_BYTE(cmd_byte), .CIDS(cids), .CADS(cads), .ADDR_MODE(addr_mode), .TALK_ONLY(talk_only),
    .LISTEN_ONLY(listen_only), .MAJOR_ADDR(MAJ), .MINOR_ADDR(MIN), .CHIP_RESET(chip_reset),
    .LOCAL_MASTER_CLEAR(lmc), .ISR_READ(isr_read), .POLL_TAKEN(poll_taken), .POLL_BYTE(poll_byte),
    .POLL_BYTE_VALID(poll_valid), .SRQ_O(srq_o), .SRQ_OE_B(srq_oe_b), .ADDR_CHANGE(addr_change));
  bus_ctrl_model ctrl (.clk(clk), .atn_b(atn_b), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .poll_taken(poll_taken), .cids(cids), .cads(cads));

  // 20 MHz clock
  always #25 clk = ~clk;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic reg_write(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : reg_write
  // Read strobe, then compare the masked answer one cycle later
  task automatic rd_chk(input string what, input logic [8:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check(what, reg_rdata & m, exp);
  endtask : rd_chk
  task automatic pulse_isr();
    @(negedge clk);
    isr_read = 1'b1;
    @(negedge clk);
    isr_read = 1'b0;
  endtask : pulse_isr

  task automatic s_reset_values();
    rd_chk("poll after reset", OFS_POLL, 8'hff, 8'h00);
    rd_chk("addr after reset", OFS_ADDR_STATUS, 8'hff, 8'hc0);
    check("no change after reset", {7'h00, addr_change}, 8'h00);
    pulse_isr();
    check("change cleared", {7'h00, addr_change}, 8'h00);
  endtask : s_reset_values
  task automatic s_request();
    reg_write(OFS_POLL, 8'hff);
    reg_write(OFS_ADDR_STATUS, 8'h00);
    rd_chk("pending set", OFS_POLL, 8'hff, 8'hff);
    check("srq driven", {7'h00, srq_oe_b}, 8'h00);
    check("srq level", {7'h00, srq_o}, 8'h00);
    rd_chk("addr not writable", OFS_ADDR_STATUS, 8'hff, 8'hc0);
    rd_chk("unmapped", 9'h100, 8'hff, 8'h00);
  endtask : s_request
  task automatic s_poll();
    int n;
    ctrl.send_cmd({3'b010, MAJ});
    rd_chk("talk addressed", OFS_ADDR_STATUS, 8'hff, 8'h82);
    check("change set", {7'h00, addr_change}, 8'h01);
    ctrl.send_cmd({1'b0, CMD_SPE});
    rd_chk("poll mode", OFS_ADDR_STATUS, 8'hff, 8'ha2);
    ctrl.set_atn(1'b1);
    for (n = 0; n < 10 && poll_valid !== 1'b1; n++)
      @(negedge clk);
    if (poll_valid !== 1'b1)
    begin
      fails++;
      tally_and_finish();
    end
    else
    begin
      check("status byte", poll_byte, 8'hff);
      check("srq released", {7'h00, srq_oe_b}, 8'h01);
      ctrl.take_byte();
      check("rsv cleared", poll_byte & 8'h40, 8'h00);
      ctrl.send_cmd({1'b0, CMD_SPD});
      repeat (2) @(negedge clk);
      check("poll offer ended", {7'h00, poll_valid}, 8'h00);
      rd_chk("pending cleared", OFS_POLL, 8'hff, 8'hbf);
      rd_chk("poll mode off", OFS_ADDR_STATUS, 8'hff, 8'h82);
    end
  endtask : s_poll
  task automatic s_listen_minor();
    ctrl.send_cmd({3'b001, MIN});
    rd_chk("minor listen", OFS_ADDR_STATUS, 8'hff, 8'h85);
    ctrl.set_atn(1'b1);
    rd_chk("atn released", OFS_ADDR_STATUS, 8'hff, 8'hc5);
    ctrl.set_idle(1'b1, 1'b0);
    rd_chk("controller idle", OFS_ADDR_STATUS, 8'hff, 8'h45);
    ctrl.set_idle(1'b0, 1'b1);
    rd_chk("controller addressed", OFS_ADDR_STATUS, 8'hff, 8'h45);
    ctrl.set_idle(1'b0, 1'b0);
  endtask : s_listen_minor
  task automatic s_ext_and_chip_reset();
    @(negedge clk);
    addr_mode = MODE_EXT_SINGLE;
    ctrl.send_cmd({1'b0, CMD_UNL});
    ctrl.send_cmd({3'b001, MAJ});
    rd_chk("listen primary", OFS_ADDR_STATUS, 8'h14, 8'h10);
    ctrl.send_cmd({3'b011, MIN});
    rd_chk("extended listen", OFS_ADDR_STATUS, 8'h14, 8'h04);
    @(negedge clk);
    addr_mode = MODE_EXT_DUAL;
    ctrl.send_cmd({3'b010, MIN});
    rd_chk("minor talk primary", OFS_ADDR_STATUS, 8'h19, 8'h09);
    ctrl.send_cmd({3'b001, MIN});
    @(negedge clk);
    lmc = 1'b1;
    @(negedge clk);
    lmc = 1'b0;
    rd_chk("primary cleared", OFS_ADDR_STATUS, 8'h38, 8'h00);
    reg_write(OFS_POLL, 8'hff);
    ctrl.set_atn(1'b1);
    @(negedge clk);
    chip_reset = 1'b1;
    @(negedge clk);
    chip_reset = 1'b0;
    repeat (2) @(negedge clk);
    rd_chk("poll chip reset", OFS_POLL, 8'hff, 8'h00);
    rd_chk("addr chip reset", OFS_ADDR_STATUS, 8'hff, 8'hc0);
  endtask : s_ext_and_chip_reset
  task automatic s_talk_only();
    @(negedge clk);
    addr_mode = MODE_TON_LON;
    pulse_isr();
    @(negedge clk);
    talk_only = 1'b1;
    repeat (2) @(negedge clk);
    rd_chk("talk only", OFS_ADDR_STATUS, 8'hff, 8'hc2);
    check("no change flag", {7'h00, addr_change}, 8'h00);
  endtask : s_talk_only

  // Reset, then the scenarios in order
  initial
  begin
    {clk, rst_b, reg_wr, reg_rd, talk_only, listen_only, chip_reset, lmc, isr_read} = '0;
    reg_addr = 9'h000;
    reg_wdata = 8'h00;
    addr_mode = MODE_DUAL;
    fails = 0;
    tests_run = 0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    s_reset_values();
    s_request();
    s_poll();
    s_listen_minor();
    s_ext_and_chip_reset();
    s_talk_only();
    tally_and_finish();
  end
endmodule : serial_poll_address_status_tb_top
